//--- include/csr_host_access_ports_map.vh
// Constants for the host access ports: widths, address windows, state codes.
// Assumes inclusion by the core access logic only.
`ifndef CSR_HOST_ACCESS_PORTS_MAP_VH
`define CSR_HOST_ACCESS_PORTS_MAP_VH

// ****************************************
// Widths
// ****************************************
`define STAT_AW          16
`define RCFG_AW          14
`define DATA_W           32
`define MEM_IDX_W        4
`define MEM_WORDS        16
`define CNT_W            16

// ****************************************
// Address windows and values
// ****************************************
`define STAT_MEM_BASE    16'h0000
`define RCFG_MEM_BASE    14'h0000
`define DATA_ZERO        32'h00000000
`define CNT_ZERO         16'h0000
`define CNT_ONE          16'h0001

// ****************************************
// Timing counts, status clock cycles
// ****************************************
`define STAT_RD_LAT      16'h0050
`define STAT_TIMEOUT     16'h0400

// ****************************************
// Status port states
// ****************************************
`define S_IDLE           2'h0
`define S_WACK           2'h1
`define S_READ           2'h2
`define S_DONE           2'h3

// ****************************************
// Reconfiguration port states
// ****************************************
`define R_IDLE           1'h0
`define R_ACK            1'h1

`endif

//--- core/csr_host_access_ports.v
// Control/status port and transceiver reconfiguration port access logic.
// Assumes one 10 MHz clock for both ports and a well-behaved bus master.
// Notes on behaviour
// - Status port timed only by status clock
// - Sampled status reset returns port to idle
// - Read data with one-cycle valid pulse
// - Wait high until request can complete
// - Fixed counter times each read, flags timeout
// - Timeout only for undefined addresses
// - Back-to-back accesses, fixed 80-cycle read latency
// - Reconfig port: 14-bit address, strobes, data
// - Reconfig port has own synchronous reset
// - Transceiver registers only via reconfig port

// Port widths below come from the map header, so it goes first
`include "csr_host_access_ports_map.vh"

module csr_host_access_ports (
	// Clock and resets
	input  wire                   sys_clk_i,
	input  wire                   rst_n_i,
	input  wire                   stat_rst_i,
	input  wire                   rcfg_rst_i,
	// Control and status port
	input  wire [`STAT_AW-1:0]    stat_addr_i,
	input  wire                   stat_read_i,
	input  wire                   stat_write_i,
	input  wire [`DATA_W-1:0]     stat_wdata_i,
	output wire [`DATA_W-1:0]     stat_rdata_o,
	output wire                   stat_rvalid_o,
	output wire                   stat_wait_o,
	output wire                   stat_timeout_o,
	// Transceiver reconfiguration port
	input  wire [`RCFG_AW-1:0]    rcfg_addr_i,
	input  wire                   rcfg_read_i,
	input  wire                   rcfg_write_i,
	input  wire [`DATA_W-1:0]     rcfg_wdata_i,
	output wire [`DATA_W-1:0]     rcfg_rdata_o,
	output wire                   rcfg_wait_o
);

// ****************************************
// Address decode
// ****************************************
function in_window;
	input [`STAT_AW-1:0] addr;
	input [`STAT_AW-1:0] base;
	begin
		in_window = (addr >= base) && (addr < base + `MEM_WORDS);
	end
endfunction

// ****************************************
// Status port state
// ****************************************
reg [1:0]            st_q;
reg [`CNT_W-1:0]     cnt_q;
reg [`DATA_W-1:0]    stat_rdata_q;
reg                  stat_rvalid_q;
reg                  stat_wait_q;
reg                  stat_timeout_q;
reg [`DATA_W-1:0]    stat_mem [0:`MEM_WORDS-1];

wire                 stat_hit;
wire [`MEM_IDX_W-1:0] stat_idx;

assign stat_hit = in_window(stat_addr_i, `STAT_MEM_BASE);
assign stat_idx = stat_addr_i[`MEM_IDX_W-1:0];

assign stat_rdata_o   = stat_rdata_q;
assign stat_rvalid_o  = stat_rvalid_q;
assign stat_wait_o    = stat_wait_q;
assign stat_timeout_o = stat_timeout_q;

// Storage has no reset; contents are software-defined
always @(posedge sys_clk_i) begin
	if (st_q == `S_WACK && stat_write_i && !stat_wait_q && stat_hit && !stat_rst_i) begin
		stat_mem[stat_idx] <= stat_wdata_i;
	end
end

always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		st_q           <= `S_IDLE;
		cnt_q          <= `CNT_ZERO;
		stat_rdata_q   <= `DATA_ZERO;
		stat_rvalid_q  <= 1'b0;
		stat_wait_q    <= 1'b1;
		stat_timeout_q <= 1'b0;
	end else if (stat_rst_i) begin
		st_q           <= `S_IDLE;
		cnt_q          <= `CNT_ZERO;
		stat_rdata_q   <= `DATA_ZERO;
		stat_rvalid_q  <= 1'b0;
		stat_wait_q    <= 1'b1;
		stat_timeout_q <= 1'b0;
	end else begin
		case (st_q)
		`S_IDLE: begin
			stat_wait_q <= 1'b1;
			if (stat_write_i) begin
				stat_wait_q <= 1'b0;
				st_q        <= `S_WACK;
			end else if (stat_read_i) begin
				cnt_q <= `CNT_ZERO;
				st_q  <= `S_READ;
			end
		end
		`S_WACK: begin
			// Write lands in this cycle; port rearms for the next access
			stat_wait_q <= 1'b1;
			st_q        <= `S_IDLE;
		end
		`S_READ: begin
			cnt_q <= cnt_q + `CNT_ONE;
			if (stat_hit && cnt_q == `STAT_RD_LAT - `CNT_ONE) begin
				stat_rdata_q  <= stat_mem[stat_idx];
				stat_rvalid_q <= 1'b1;
				stat_wait_q   <= 1'b0;
				st_q          <= `S_DONE;
			end else if (cnt_q == `STAT_TIMEOUT - `CNT_ONE) begin
				stat_rdata_q   <= `DATA_ZERO;
				stat_timeout_q <= 1'b1;
				stat_wait_q    <= 1'b0;
				st_q           <= `S_DONE;
			end
		end
		`S_DONE: begin
			stat_rvalid_q  <= 1'b0;
			stat_timeout_q <= 1'b0;
			stat_wait_q    <= 1'b1;
			st_q           <= `S_IDLE;
		end
		default: begin
			st_q        <= `S_IDLE;
			stat_wait_q <= 1'b1;
		end
		endcase
	end
end

// ****************************************
// Reconfiguration port
// ****************************************
reg                  rs_q;
reg [`DATA_W-1:0]    rcfg_rdata_q;
reg                  rcfg_wait_q;
reg [`DATA_W-1:0]    xcvr_mem [0:`MEM_WORDS-1];

wire                 rcfg_hit;
wire [`MEM_IDX_W-1:0] rcfg_idx;

// Transceiver storage decoded from this port alone
assign rcfg_hit = in_window({{(`STAT_AW-`RCFG_AW){1'b0}}, rcfg_addr_i},
	{{(`STAT_AW-`RCFG_AW){1'b0}}, `RCFG_MEM_BASE});
assign rcfg_idx = rcfg_addr_i[`MEM_IDX_W-1:0];

assign rcfg_rdata_o = rcfg_rdata_q;
assign rcfg_wait_o  = rcfg_wait_q;

always @(posedge sys_clk_i) begin
	if (rs_q == `R_ACK && rcfg_write_i && !rcfg_wait_q && rcfg_hit && !rcfg_rst_i) begin
		xcvr_mem[rcfg_idx] <= rcfg_wdata_i;
	end
end

always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		rs_q         <= `R_IDLE;
		rcfg_rdata_q <= `DATA_ZERO;
		rcfg_wait_q  <= 1'b1;
	end else if (rcfg_rst_i) begin
		rs_q         <= `R_IDLE;
		rcfg_rdata_q <= `DATA_ZERO;
		rcfg_wait_q  <= 1'b1;
	end else begin
		case (rs_q)
		`R_IDLE: begin
			rcfg_wait_q <= 1'b1;
			if (rcfg_write_i || rcfg_read_i) begin
				// Unmapped reads return zero
				rcfg_rdata_q <= rcfg_hit ? xcvr_mem[rcfg_idx] : `DATA_ZERO;
				rcfg_wait_q  <= 1'b0;
				rs_q         <= `R_ACK;
			end
		end
		`R_ACK: begin
			rcfg_wait_q <= 1'b1;
			rs_q        <= `R_IDLE;
		end
		default: begin
			rs_q        <= `R_IDLE;
			rcfg_wait_q <= 1'b1;
		end
		endcase
	end
end

endmodule

//--- test/csr_host_access_ports_checker.sv
// Checker for the host access ports.
// Assumes one clock and the asynchronous active-low reset.
module csr_host_access_ports_checker (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic stat_rst_i,
	input wire logic rcfg_rst_i,
	input wire logic stat_read_i,
	input wire logic stat_write_i,
	input wire logic stat_rvalid_o,
	input wire logic stat_wait_o,
	input wire logic stat_timeout_o,
	input wire logic rcfg_wait_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wdone; stat_write_i && !stat_wait_o; endsequence
	sequence s_idle; stat_wait_o && !stat_rvalid_o; endsequence
	property p_wr; s_wdone |=> s_idle; endproperty
	a_wr: assert property (p_wr) else $error("write ack");
	property p_rv; stat_rvalid_o |-> !stat_wait_o && !stat_timeout_o; endproperty
	a_rv: assert property (p_rv) else $error("rvalid");
	property p_rvp; stat_rvalid_o |=> s_idle; endproperty
	a_rvp: assert property (p_rvp) else $error("rvalid pulse");
	property p_lat; stat_rvalid_o |-> $past(stat_read_i, 80); endproperty
	a_lat: assert property (p_lat) else $error("latency");
	property p_to; stat_timeout_o |-> !stat_wait_o && $past(stat_read_i, 1024); endproperty
	a_to: assert property (p_to) else $error("timeout");
	property p_srst; stat_rst_i |=> stat_wait_o && !stat_rvalid_o && !stat_timeout_o; endproperty
	a_srst: assert property (p_srst) else $error("stat reset");
	property p_rc; !rcfg_wait_o |=> rcfg_wait_o; endproperty
	a_rc: assert property (p_rc) else $error("rcfg wait");
	property p_rrst; rcfg_rst_i |=> rcfg_wait_o; endproperty
	a_rrst: assert property (p_rrst) else $error("rcfg reset");
endmodule

bind csr_host_access_ports csr_host_access_ports_checker u_chk (.*);

//--- test/csr_host_model.sv
// Bus master on the status port.
// Assumes the core's registered wait output.
module csr_host_model (
	input  wire logic        sys_clk_i,
	input  wire logic        wait_i,
	output logic      [15:0] addr_o,
	output logic             read_o,
	output logic             write_o,
	output logic      [31:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{read_o, write_o, addr_o, wdata_o} = '0;
	end
	// Holds the request until wait is seen low
	task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d, output int n);
		n = 0;
		@(negedge sys_clk_i);
		addr_o = a;
		read_o = !wr;
		write_o = wr;
		wdata_o = d;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (wait_i && n < 2000);
	endtask
	task automatic idle();
		@(negedge sys_clk_i);
		read_o = 0;
		write_o = 0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
	endtask
endmodule

//--- test/csr_host_access_ports_test.sv
// Self-checking bench for the host access ports.
// Assumes the core and the map header are compiled first.
module csr_host_access_ports_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i, rst_n_i, stat_rst_i, rcfg_rst_i, stat_read_i, stat_write_i;
	logic stat_rvalid_o, stat_wait_o, stat_timeout_o, rcfg_read_i, rcfg_write_i, rcfg_wait_o;
	logic [15:0] stat_addr_i;
	logic [13:0] rcfg_addr_i;
	logic [31:0] stat_wdata_i, stat_rdata_o, rcfg_wdata_i, rcfg_rdata_o;
	int errors = 0, checks_done = 0, cyc = 0, n;
	csr_host_access_ports u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.stat_rst_i(stat_rst_i), .rcfg_rst_i(rcfg_rst_i), .stat_addr_i(stat_addr_i),
		.stat_read_i(stat_read_i), .stat_write_i(stat_write_i), .stat_wdata_i(stat_wdata_i),
		.stat_rdata_o(stat_rdata_o), .stat_rvalid_o(stat_rvalid_o), .stat_wait_o(stat_wait_o),
		.stat_timeout_o(stat_timeout_o), .rcfg_addr_i(rcfg_addr_i), .rcfg_read_i(rcfg_read_i),
		.rcfg_write_i(rcfg_write_i), .rcfg_wdata_i(rcfg_wdata_i), .rcfg_rdata_o(rcfg_rdata_o),
		.rcfg_wait_o(rcfg_wait_o));
	csr_host_model u_host (.sys_clk_i(sys_clk_i), .wait_i(stat_wait_o), .addr_o(stat_addr_i),
		.read_o(stat_read_i), .write_o(stat_write_i), .wdata_o(stat_wdata_i));
	always #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (++cyc == 3000) begin
		errors++;
		complete_run();
	end
	task automatic chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: %h %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic racc(input logic wr, input logic [13:0] a, input logic [31:0] d);
		@(negedge sys_clk_i);
		{rcfg_addr_i, rcfg_read_i, rcfg_write_i, rcfg_wdata_i} = {a, !wr, wr, d};
		@(negedge sys_clk_i);
		chk(rcfg_wait_o, 0);
		@(negedge sys_clk_i);
		{rcfg_addr_i, rcfg_read_i, rcfg_write_i} = {~a, 2'h0};
	endtask
	task automatic t_wr_rd();
		u_host.acc(1, 16'h000F, 32'hDEADBEEF, n);
		chk(n, 1);
		u_host.acc(0, 16'h000F, 32'h0, n);
		chk(n, 81);
		chk(stat_rvalid_o, 1);
		chk(stat_rdata_o, 32'hDEADBEEF);
		u_host.idle();
		$display("wr_rd done");
	endtask
	task automatic t_to();
		u_host.acc(0, 16'h0100, 32'h0, n);
		chk(n, 1025);
		chk({stat_timeout_o, stat_rvalid_o}, 2);
		u_host.idle();
		$display("timeout done");
	endtask
	task automatic t_rcfg();
		u_host.acc(1, 16'h0003, 32'hA5A5A5A5, n);
		u_host.idle();
		racc(1, 14'h0003, 32'h12345678);
		racc(0, 14'h0003, 32'h0);
		chk(rcfg_rdata_o, 32'h12345678);
		racc(0, 14'h0020, 32'h0);
		chk(rcfg_rdata_o, 32'h0);
		u_host.acc(0, 16'h0003, 32'h0, n);
		chk(stat_rdata_o, 32'hA5A5A5A5);
		u_host.idle();
		$display("rcfg done");
	endtask
	task automatic t_rst();
		@(negedge sys_clk_i);
		{stat_rst_i, rcfg_rst_i} = 2'h3;
		@(negedge sys_clk_i);
		chk({stat_wait_o, rcfg_wait_o, stat_rvalid_o}, 6);
		{stat_rst_i, rcfg_rst_i} = 2'h0;
		$display("reset done");
	endtask
	initial begin
		{sys_clk_i, rst_n_i, stat_rst_i, rcfg_rst_i} = '0;
		{rcfg_addr_i, rcfg_read_i, rcfg_write_i, rcfg_wdata_i} = '0;
		repeat (20) @(negedge sys_clk_i);
		rst_n_i = 1;
		t_wr_rd();
		t_to();
		t_rcfg();
		t_rst();
		complete_run();
	end
endmodule
